// ==== bench/psm_line_partner.sv ====
`timescale 1ns/1ns
module psm_line_partner (
	// clock
	input wire logic ref_clk_in,
	// block stream toward the port
	output logic blk_valid_out,
	output logic [1:0] blk_sync_out,
	output logic [63:0] blk_payload_out
);
	initial begin
		blk_valid_out = 1'b0;
		blk_sync_out = 2'b01;
		blk_payload_out = 64'h0;
	end

	// one block for one cycle, then the lines show the inverse
	task automatic send(input logic [1:0] sh, input logic [63:0] pl);
		@(posedge ref_clk_in);
		blk_valid_out <= 1'b1;
		blk_sync_out <= sh;
		blk_payload_out <= pl;
		@(posedge ref_clk_in);
		blk_valid_out <= 1'b0;
		blk_sync_out <= ~sh;
		blk_payload_out <= ~pl;
	endtask
endmodule // psm_line_partner

// ==== bench/psm_top_asserts.sv ====
`timescale 1ns/1ns
module psm_top_asserts import psm_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// bus
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	// link and interrupt
	input wire logic link_up_in,
	input wire logic loopback_en_in,
	input wire logic [1:0] link_state_out,
	input wire logic irq_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////
	wait_first_a: assert property ((avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in)
		|-> avs_waitrequest_out) else $error("new request not held");
	wait_once_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("more than one wait cycle");
	idle_free_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
		else $error("wait without request");
	rdata_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out)) else $error("read data moved");
	// the edge that releases reset still resets the link register, so it is no antecedent
	link_down_a: assert property (rst_n_in && !link_up_in && !loopback_en_in
		|=> link_state_out == PSM_LINK_DOWN) else $error("link not down");
	link_up_a: assert property (rst_n_in && link_up_in && !loopback_en_in
		|=> link_state_out == PSM_LINK_UP) else $error("link not up");
	link_loop_a: assert property (rst_n_in && loopback_en_in |=> link_state_out == PSM_LINK_LOOP)
		else $error("link not loopback");
	link_code_a: assert property (link_state_out != 2'b11) else $error("illegal link code");

	read_done_c: cover property (avs_read_in && !avs_waitrequest_out);
	irq_rise_c: cover property ($rose(irq_out));
	loop_seen_c: cover property (link_state_out == PSM_LINK_LOOP);
endmodule // psm_top_asserts

bind psm_top psm_top_asserts chk_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.link_up_in(link_up_in), .loopback_en_in(loopback_en_in), .link_state_out(link_state_out), .irq_out(irq_out));

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench import psm_pkg::*;;
	typedef struct {string n; logic [31:0] v;} psm_note_s;
	logic ref_clk_in = 0;
	logic rst_n_in = 0;
	logic [7:0] avs_address_in = 0;
	logic avs_read_in = 0;
	logic avs_write_in = 0;
	logic [31:0] avs_writedata_in = 0;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic rx_blk_valid_in;
	logic [1:0] rx_blk_sync_in;
	logic [63:0] rx_blk_payload_in;
	logic tx_frame_done_in = 0, tx_frame_ok_in = 0, rx_frame_done_in = 0, rx_fcs_ok_in = 0;
	logic rx_vlan_tagged_in = 0, rx_trig_match_in = 0, rx_filt_match_in = 0, link_up_in = 0, loopback_en_in = 0;
	logic [15:0] tx_frame_len_in = 0, rx_frame_len_in = 0;
	logic [2:0] rx_frame_extra_bits_in = 0;
	logic [3:0] rx_custom_match_in = 0;
	logic [1:0] link_state_out;
	logic irq_out;
	int miscompares = 0, n_compared = 0;
	logic [31:0] ec [PSM_NUM_CNT];
	logic [63:0] et [PSM_NUM_TOT];
	psm_note_s q[$];
	logic [7:0] tt [8] = '{PSM_BT_T0, PSM_BT_T1, PSM_BT_T2, PSM_BT_T3, PSM_BT_T4, PSM_BT_T5, PSM_BT_T6, PSM_BT_T7};
	logic [15:0] rl [9] = '{16'h003f, 16'h0040, 16'h05ee, 16'h05ef, 16'h05ef, 16'h05f1, 16'h05f2, 16'h0040, 16'h0040};
	logic [8:0] rv = 9'h070;
	logic [8:0] rf = 9'h0ff;

	initial forever #4 ref_clk_in = ~ref_clk_in;

	psm_line_partner far (.ref_clk_in, .blk_valid_out(rx_blk_valid_in), .blk_sync_out(rx_blk_sync_in),
		.blk_payload_out(rx_blk_payload_in));
	psm_top uut (.ref_clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
		.avs_readdata_out, .avs_waitrequest_out, .rx_blk_valid_in, .rx_blk_sync_in, .rx_blk_payload_in,
		.tx_frame_done_in, .tx_frame_ok_in, .tx_frame_len_in, .rx_frame_done_in, .rx_frame_len_in,
		.rx_frame_extra_bits_in, .rx_fcs_ok_in, .rx_vlan_tagged_in, .rx_trig_match_in, .rx_filt_match_in,
		.rx_custom_match_in, .link_up_in, .loopback_en_in, .link_state_out, .irq_out);

	////////////////////////////////////////
	task automatic chk(input string w, input logic [63:0] s, input logic [63:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic close_out();
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// waitrequest is looked at as it stands at each rising edge
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge ref_clk_in);
		avs_address_in <= a;
		avs_read_in <= !wr;
		avs_write_in <= wr;
		avs_writedata_in <= d;
		do begin
			@(posedge ref_clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back('{$sformatf("reg %h", a), e});
		bus(a, 1'b0, 32'h0);
	endtask

	task automatic rd_all();
		for (int i = 0; i < PSM_NUM_CNT; i++) rd(PSM_OFS_CNT_BASE + 8'(4 * i), ec[i]);
		for (int j = 0; j < PSM_NUM_TOT; j++) begin
			rd(PSM_OFS_TOT_BASE + 8'(8 * j), et[j][31:0]);
			rd(PSM_OFS_TOT_BASE + 8'(8 * j + 4), et[j][63:32]);
		end
	endtask

	task automatic zero();
		foreach (ec[i]) ec[i] = 0;
		foreach (et[i]) et[i] = 0;
	endtask

	task automatic blk(input logic [1:0] sh, input logic [63:0] pl, input int s);
		far.send(sh, pl);
		if (s >= 0) ec[s]++;
	endtask

	task automatic txf(input logic ok, input logic [15:0] len);
		@(posedge ref_clk_in);
		tx_frame_done_in <= 1'b1;
		tx_frame_ok_in <= ok;
		tx_frame_len_in <= len;
		@(posedge ref_clk_in);
		tx_frame_done_in <= 1'b0;
		if (ok) ec[PSM_C_TX_FRAME]++;
		et[PSM_T_TX_BYTE] += len;
		et[PSM_T_TX_BIT] += 64'(len) * 8;
	endtask

	task automatic rxf(input logic [15:0] len, input logic [2:0] x, input logic fcs, input logic vlan);
		logic [5:0] m;
		m = 6'($urandom);
		@(posedge ref_clk_in);
		rx_frame_done_in <= 1'b1;
		rx_frame_len_in <= len;
		rx_frame_extra_bits_in <= x;
		rx_fcs_ok_in <= fcs;
		rx_vlan_tagged_in <= vlan;
		rx_trig_match_in <= m[0];
		rx_filt_match_in <= m[1];
		rx_custom_match_in <= m[5:2];
		@(posedge ref_clk_in);
		rx_frame_done_in <= 1'b0;
		if (x == 0 && fcs && ((len >= PSM_MIN_LEN && len <= PSM_MAX_LEN) ||
			(vlan && len > PSM_MAX_LEN && len < PSM_VLAN_LIM))) ec[PSM_C_RX_VALID]++;
		ec[PSM_C_TRIG] += m[0];
		ec[PSM_C_FILT] += m[1];
		for (int i = 0; i < PSM_NUM_CUSTOM; i++) ec[PSM_C_CUSTOM + i] += m[2 + i];
		et[PSM_T_RX_BYTE] += len;
		et[PSM_T_RX_BIT] += 64'(len) * 8 + x;
	endtask

	// read results are compared in order of the notes
	// taken at the rising edge that ends the read, as the data stands there
	always @(posedge ref_clk_in) begin
		if (avs_read_in && avs_waitrequest_out === 1'b0) begin
			if (q.size() == 0) begin
				chk("read note", 64'h1, 64'h0);
			end else begin
				chk(q[0].n, avs_readdata_out, q[0].v);
				void'(q.pop_front());
			end
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		miscompares++;
		close_out();
	end

	////////////////////////////////////////
	initial begin
		zero();
		void'($urandom(32'h9677));
		repeat (12) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rd_all();
		rd(8'hfc, 32'h0);
		bus(PSM_OFS_IRQ_MASK, 1'b1, 32'h1);
		blk(2'b00, {$urandom, $urandom}, PSM_C_SYNC);
		blk(2'b11, {$urandom, $urandom}, PSM_C_SYNC);
		blk(PSM_SH_DATA, {$urandom, $urandom}, -1);
		foreach (tt[i]) blk(PSM_SH_CTRL, {56'h0, tt[i]}, -1);
		blk(PSM_SH_CTRL, 64'h2d, PSM_C_BAD_TYPE);
		blk(PSM_SH_CTRL, {32'h0, 24'h03_00_00, PSM_BT_OSET}, PSM_C_BAD_OS);
		blk(PSM_SH_CTRL, {56'h0, PSM_BT_IDLE}, -1);
		blk(PSM_SH_CTRL, {48'h0, 8'h01, PSM_BT_IDLE}, PSM_C_BAD_IDLE);
		blk(PSM_SH_CTRL, {PSM_PREAMBLE, PSM_BT_START}, -1);
		blk(PSM_SH_CTRL, {PSM_PREAMBLE ^ 56'h1, PSM_BT_START}, PSM_C_BAD_START);
		blk(PSM_SH_CTRL, {32'h0, PSM_OS_REMOTE, PSM_BT_OSET}, PSM_C_REMOTE);
		blk(PSM_SH_CTRL, {32'h0, PSM_OS_LOCAL, PSM_BT_OSET}, PSM_C_LOCAL);
		bus(PSM_OFS_CTRL, 1'b1, 32'h1);
		rd(PSM_OFS_CTRL, 32'h1);
		blk(PSM_SH_CTRL, {~PSM_PREAMBLE, PSM_BT_START}, -1);
		repeat (4) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk("irq", irq_out, 1);
		bus(PSM_OFS_IRQ_STAT, 1'b1, 32'h7f);
		blk(PSM_SH_CTRL, 64'h2d, PSM_C_BAD_TYPE);
		repeat (4) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk("irq", irq_out, 0);
		txf(1'b1, 16'h05ee);
		txf(1'b0, 16'h0100);
		foreach (rl[i]) rxf(rl[i], (i == 7) ? 3'h4 : 3'h0, rf[i], rv[i]);
		repeat (4) rxf(16'($urandom_range(60, 1530)), 3'h0, 1'($urandom), 1'($urandom));
		repeat (3) @(posedge ref_clk_in);
		rd_all();
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk_in);
			link_up_in <= k[0];
			loopback_en_in <= k[1];
			rd(PSM_OFS_LINK, k[1] ? 32'h2 : 32'(k[0]));
		end
		// the clear bit empties every count and total and reads back as zero
		bus(PSM_OFS_CTRL, 1'b1, 32'h2);
		zero();
		rd_all();
		rd(PSM_OFS_CTRL, 32'h0);
		// a reset in mid-run empties counts that are not zero
		blk(2'b00, {$urandom, $urandom}, PSM_C_SYNC);
		txf(1'b1, 16'h0040);
		rd(PSM_OFS_CNT_BASE, ec[PSM_C_SYNC]);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		zero();
		rd_all();
		rd(PSM_OFS_LINK, 32'h2);
		repeat (2) @(posedge ref_clk_in);
		chk("notes left", q.size(), 0);
		close_out();
	end
endmodule // testbench

// ==== rtl/psm_block_check.sv ====
`timescale 1ns/1ns
module psm_block_check import psm_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// received block
	input wire logic blk_valid_in,
	input wire logic [1:0] blk_sync_in,
	input wire logic [63:0] blk_payload_in,
	input wire logic prog_pre_in,
	// one-cycle events, slot order of psm_pkg
	output logic [PSM_NUM_EVT-1:0] evt_out
);

	typedef struct packed {
		logic [PSM_NUM_EVT-1:0] evt;
	} psm_chk_s;

	psm_chk_s st_ff;
	psm_chk_s nxt_st;
	logic is_ctrl;
	logic all_idle;
	logic [7:0] btype;

	always_comb begin
		btype = blk_payload_in[7:0];
		is_ctrl = blk_sync_in == PSM_SH_CTRL;
		all_idle = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (blk_payload_in[8 + 7 * i +: 7] != PSM_CC_IDLE) begin
				all_idle = 1'b0;
			end
		end
		nxt_st.evt = '0;
		if (blk_valid_in) begin
			nxt_st.evt[PSM_C_SYNC] = !is_ctrl && blk_sync_in != PSM_SH_DATA;
			if (is_ctrl) begin
				nxt_st.evt[PSM_C_BAD_TYPE] = !psm_known_type(btype);
				if (btype == PSM_BT_OSET) begin
					if (blk_payload_in[63:32] == 32'h0 && blk_payload_in[31:8] == PSM_OS_LOCAL) begin
						nxt_st.evt[PSM_C_LOCAL] = 1'b1;
					end else if (blk_payload_in[63:32] == 32'h0 && blk_payload_in[31:8] == PSM_OS_REMOTE) begin
						nxt_st.evt[PSM_C_REMOTE] = 1'b1;
					end else begin
						nxt_st.evt[PSM_C_BAD_OS] = 1'b1;
					end
				end
				nxt_st.evt[PSM_C_BAD_IDLE] = btype == PSM_BT_IDLE && !all_idle;
				nxt_st.evt[PSM_C_BAD_START] = btype == PSM_BT_START && !prog_pre_in
					&& blk_payload_in[63:8] != PSM_PREAMBLE;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign evt_out = st_ff.evt;

endmodule // psm_block_check

// ==== rtl/psm_pkg.sv ====
// What this block does
// - count blocks whose sync header is invalid
// - count control blocks with unknown type
// - count 0x4B blocks not local/remote fault
// - count 0x1E blocks holding non-idle codes
// - count 0x78 blocks with wrong preamble
// - programmable preamble mode suppresses start errors
// - count each remote fault ordered set
// - count each local fault ordered set
// - count only successfully transmitted frames
// - valid frame: 64..1518 bytes, whole octets
// - 32-bit valid counter, good FCS only
// - VLAN frames 1519..1521 bytes also valid
// - running totals of bytes sent and received
// - running totals of bits sent and received
// - count capture trigger matches
// - count capture filter matches
// - user-defined match counters
// - link state: up, loopback or down
package psm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int PSM_CNT_W = 32;
	localparam int PSM_TOT_W = 64;
	localparam int PSM_NUM_CNT = 15;
	localparam int PSM_NUM_TOT = 4;
	localparam int PSM_NUM_EVT = 7;
	localparam int PSM_ADDR_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// 32-bit counter slots; slots 0..6 follow the block event order
	localparam int PSM_C_SYNC = 0;
	localparam int PSM_C_BAD_TYPE = 1;
	localparam int PSM_C_BAD_OS = 2;
	localparam int PSM_C_BAD_IDLE = 3;
	localparam int PSM_C_BAD_START = 4;
	localparam int PSM_C_REMOTE = 5;
	localparam int PSM_C_LOCAL = 6;
	localparam int PSM_C_TX_FRAME = 7;
	localparam int PSM_C_RX_VALID = 8;
	localparam int PSM_C_TRIG = 9;
	localparam int PSM_C_FILT = 10;
	localparam int PSM_C_CUSTOM = 11;
	localparam int PSM_NUM_CUSTOM = 4;

	// 64-bit totals slots
	localparam int PSM_T_TX_BYTE = 0;
	localparam int PSM_T_RX_BYTE = 1;
	localparam int PSM_T_TX_BIT = 2;
	localparam int PSM_T_RX_BIT = 3;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] PSM_OFS_CTRL = 8'h00;
	localparam logic [7:0] PSM_OFS_LINK = 8'h04;
	localparam logic [7:0] PSM_OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] PSM_OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] PSM_OFS_CNT_BASE = 8'h40;
	localparam logic [7:0] PSM_OFS_TOT_BASE = 8'h80;

	// control fields and reset values
	localparam int PSM_CTRL_PROG_PRE = 0;
	localparam int PSM_CTRL_CLEAR = 1;
	localparam logic PSM_RST_PROG_PRE = 1'b0;
	localparam logic [PSM_NUM_EVT-1:0] PSM_RST_IRQ_MASK = 7'h00;

	////////////////////////////////////////////////////////////////////////////////
	// 64b/66b coding
	localparam logic [1:0] PSM_SH_DATA = 2'b01;
	localparam logic [1:0] PSM_SH_CTRL = 2'b10;
	localparam logic [7:0] PSM_BT_IDLE = 8'h1e;
	localparam logic [7:0] PSM_BT_START = 8'h78;
	localparam logic [7:0] PSM_BT_OSET = 8'h4b;
	localparam logic [7:0] PSM_BT_T0 = 8'h87;
	localparam logic [7:0] PSM_BT_T1 = 8'h99;
	localparam logic [7:0] PSM_BT_T2 = 8'haa;
	localparam logic [7:0] PSM_BT_T3 = 8'hb4;
	localparam logic [7:0] PSM_BT_T4 = 8'hcc;
	localparam logic [7:0] PSM_BT_T5 = 8'hd2;
	localparam logic [7:0] PSM_BT_T6 = 8'he1;
	localparam logic [7:0] PSM_BT_T7 = 8'hff;
	localparam logic [6:0] PSM_CC_IDLE = 7'h00;
	localparam logic [55:0] PSM_PREAMBLE = 56'hd5_55_55_55_55_55_55;
	localparam logic [23:0] PSM_OS_LOCAL = 24'h01_00_00;
	localparam logic [23:0] PSM_OS_REMOTE = 24'h02_00_00;

	////////////////////////////////////////////////////////////////////////////////
	// frame size limits in bytes
	localparam logic [15:0] PSM_MIN_LEN = 16'd64;
	localparam logic [15:0] PSM_MAX_LEN = 16'd1518;
	localparam logic [15:0] PSM_VLAN_LIM = 16'd1522;

	typedef enum logic [1:0] {
		PSM_LINK_DOWN = 2'b00,
		PSM_LINK_UP = 2'b01,
		PSM_LINK_LOOP = 2'b10
	} psm_link_e;

	function automatic logic psm_known_type(input logic [7:0] bt);
		case (bt)
			PSM_BT_IDLE, PSM_BT_START, PSM_BT_OSET, PSM_BT_T0, PSM_BT_T1,
			PSM_BT_T2, PSM_BT_T3, PSM_BT_T4, PSM_BT_T5, PSM_BT_T6, PSM_BT_T7: psm_known_type = 1'b1;
			default: psm_known_type = 1'b0;
		endcase
	endfunction

endpackage

// ==== rtl/psm_top.sv ====
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
module psm_top import psm_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,

	// avalon-mm slave
	input wire logic [PSM_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,

	// received 64b/66b blocks
	input wire logic rx_blk_valid_in,
	input wire logic [1:0] rx_blk_sync_in,
	input wire logic [63:0] rx_blk_payload_in,

	// transmit frame end
	input wire logic tx_frame_done_in,
	input wire logic tx_frame_ok_in,
	input wire logic [15:0] tx_frame_len_in,

	// receive frame end
	input wire logic rx_frame_done_in,
	input wire logic [15:0] rx_frame_len_in,
	input wire logic [2:0] rx_frame_extra_bits_in,
	input wire logic rx_fcs_ok_in,
	input wire logic rx_vlan_tagged_in,
	input wire logic rx_trig_match_in,
	input wire logic rx_filt_match_in,
	input wire logic [PSM_NUM_CUSTOM-1:0] rx_custom_match_in,

	// link
	input wire logic link_up_in,
	input wire logic loopback_en_in,
	output logic [1:0] link_state_out,

	// interrupt
	output logic irq_out
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [PSM_NUM_CNT-1:0][PSM_CNT_W-1:0] cnt;
		logic [PSM_NUM_TOT-1:0][PSM_TOT_W-1:0] tot;
		logic [31:0] hi_shadow;
		logic [31:0] rdata;
		logic ack;
		logic prog_pre;
		logic [PSM_NUM_EVT-1:0] irq_stat;
		logic [PSM_NUM_EVT-1:0] irq_mask;
		psm_link_e link;
		logic irq;
	} psm_state_s;

	psm_state_s st_ff;
	psm_state_s nxt_st;

	logic [PSM_NUM_EVT-1:0] blk_evt;
	logic [PSM_NUM_CNT-1:0] inc;
	logic rx_valid;
	logic req;
	logic wr_take;
	logic rd_lo;
	logic clear;
	logic [PSM_TOT_W-1:0] tx_bytes;
	logic [PSM_TOT_W-1:0] rx_bytes;
	logic [PSM_TOT_W-1:0] tx_bits;
	logic [PSM_TOT_W-1:0] rx_bits;
	logic [PSM_NUM_EVT-1:0] w1c;
	logic [3:0] bus_ts;

	////////////////////////////////////////////////////////////////////////////////
	// block checker

	psm_block_check u_block_check (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.blk_valid_in(rx_blk_valid_in),
		.blk_sync_in(rx_blk_sync_in),
		.blk_payload_in(rx_blk_payload_in),
		.prog_pre_in(st_ff.prog_pre),
		.evt_out(blk_evt)
	);

	////////////////////////////////////////////////////////////////////////////////
	// decoding

	// counter slot addressed by a byte address, or all ones if none
	function automatic logic [4:0] cnt_slot(input logic [PSM_ADDR_W-1:0] a);
		logic [PSM_ADDR_W-1:0] d;
		d = a - PSM_OFS_CNT_BASE;
		if (a >= PSM_OFS_CNT_BASE && a < PSM_OFS_TOT_BASE && d[1:0] == 2'b00
			&& d[7:2] < 6'(PSM_NUM_CNT)) begin
			cnt_slot = d[6:2];
		end else begin
			cnt_slot = 5'h1f;
		end
	endfunction

	// totals slot and half; bit 0 selects the high word
	function automatic logic [3:0] tot_slot(input logic [PSM_ADDR_W-1:0] a);
		logic [PSM_ADDR_W-1:0] d;
		d = a - PSM_OFS_TOT_BASE;
		if (a >= PSM_OFS_TOT_BASE && d[1:0] == 2'b00 && d[7:2] < 6'(2 * PSM_NUM_TOT)) begin
			tot_slot = d[5:2];
		end else begin
			tot_slot = 4'hf;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// frame qualification

	always_comb begin
		rx_valid = rx_fcs_ok_in && rx_frame_extra_bits_in == 3'h0
			&& ((rx_frame_len_in >= PSM_MIN_LEN && rx_frame_len_in <= PSM_MAX_LEN)
			|| (rx_vlan_tagged_in && rx_frame_len_in > PSM_MAX_LEN
			&& rx_frame_len_in < PSM_VLAN_LIM));
		tx_bytes = {48'h0, tx_frame_len_in};
		rx_bytes = {48'h0, rx_frame_len_in};
		tx_bits = {45'h0, tx_frame_len_in, 3'h0};
		rx_bits = {45'h0, rx_frame_len_in, rx_frame_extra_bits_in};
	end

	always_comb begin
		inc = '0;
		inc[PSM_NUM_EVT-1:0] = blk_evt;
		inc[PSM_C_TX_FRAME] = tx_frame_done_in && tx_frame_ok_in;
		inc[PSM_C_RX_VALID] = rx_frame_done_in && rx_valid;
		inc[PSM_C_TRIG] = rx_frame_done_in && rx_trig_match_in;
		inc[PSM_C_FILT] = rx_frame_done_in && rx_filt_match_in;
		for (int k = 0; k < PSM_NUM_CUSTOM; k++) begin
			inc[PSM_C_CUSTOM + k] = rx_frame_done_in && rx_custom_match_in[k];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake

	// one wait state: data is latched on the first edge, taken on the second
	assign req = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && !st_ff.ack;
	assign wr_take = avs_write_in && st_ff.ack;
	assign bus_ts = tot_slot(avs_address_in);
	assign rd_lo = avs_read_in && !st_ff.ack && bus_ts != 4'hf && !bus_ts[0];
	assign clear = wr_take && avs_address_in == PSM_OFS_CTRL && avs_writedata_in[PSM_CTRL_CLEAR];
	assign w1c = (wr_take && avs_address_in == PSM_OFS_IRQ_STAT)
		? avs_writedata_in[PSM_NUM_EVT-1:0] : '0;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [4:0] cs;
		logic [3:0] ts;
		cs = cnt_slot(avs_address_in);
		ts = tot_slot(avs_address_in);
		nxt_st = st_ff;

		// counters wrap through the adder width
		for (int i = 0; i < PSM_NUM_CNT; i++) begin
			if (clear) begin
				nxt_st.cnt[i] = '0;
			end else if (inc[i]) begin
				nxt_st.cnt[i] = st_ff.cnt[i] + 32'h1;
			end
		end

		if (clear) begin
			nxt_st.tot = '0;
		end else begin
			if (tx_frame_done_in) begin
				nxt_st.tot[PSM_T_TX_BYTE] = st_ff.tot[PSM_T_TX_BYTE] + tx_bytes;
				nxt_st.tot[PSM_T_TX_BIT] = st_ff.tot[PSM_T_TX_BIT] + tx_bits;
			end
			if (rx_frame_done_in) begin
				nxt_st.tot[PSM_T_RX_BYTE] = st_ff.tot[PSM_T_RX_BYTE] + rx_bytes;
				nxt_st.tot[PSM_T_RX_BIT] = st_ff.tot[PSM_T_RX_BIT] + rx_bits;
			end
		end

		// a new event wins over a clear in the same cycle
		nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | blk_evt;

		if (wr_take) begin
			case (avs_address_in)
				PSM_OFS_CTRL: begin
					nxt_st.prog_pre = avs_writedata_in[PSM_CTRL_PROG_PRE];
				end
				PSM_OFS_IRQ_MASK: begin
					nxt_st.irq_mask = avs_writedata_in[PSM_NUM_EVT-1:0];
				end
				default: begin
					nxt_st.irq_mask = st_ff.irq_mask;
				end
			endcase
		end

		if (loopback_en_in) begin
			nxt_st.link = PSM_LINK_LOOP;
		end else if (link_up_in) begin
			nxt_st.link = PSM_LINK_UP;
		end else begin
			nxt_st.link = PSM_LINK_DOWN;
		end

		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

		// read data: latched on the first edge of a request
		nxt_st.ack = req && !st_ff.ack;
		if (avs_read_in && !st_ff.ack) begin
			if (cs != 5'h1f) begin
				nxt_st.rdata = st_ff.cnt[cs];
			end else if (ts != 4'hf) begin
				if (ts[0]) begin
					nxt_st.rdata = st_ff.hi_shadow;
				end else begin
					nxt_st.rdata = st_ff.tot[ts[3:1]][31:0];
				end
			end else begin
				case (avs_address_in)
					PSM_OFS_CTRL: nxt_st.rdata = {31'h0, st_ff.prog_pre};
					PSM_OFS_LINK: nxt_st.rdata = {30'h0, st_ff.link};
					PSM_OFS_IRQ_STAT: nxt_st.rdata = {25'h0, st_ff.irq_stat};
					PSM_OFS_IRQ_MASK: nxt_st.rdata = {25'h0, st_ff.irq_mask};
					default: nxt_st.rdata = 32'h0;
				endcase
			end
		end
		// reading a low word freezes its high word for the next read
		if (rd_lo) begin
			nxt_st.hi_shadow = st_ff.tot[ts[3:1]][63:32];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
			st_ff.prog_pre <= PSM_RST_PROG_PRE;
			st_ff.irq_mask <= PSM_RST_IRQ_MASK;
			st_ff.link <= PSM_LINK_DOWN;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign avs_readdata_out = st_ff.rdata;
	assign link_state_out = st_ff.link;
	assign irq_out = st_ff.irq;

endmodule // psm_top
